// >>> irs_pkg.sv
// Purpose: shared constants for the low-battery route, software request
//          and status-two register block
// Assumes: AXI4-Lite, 32-bit data, registers 16 bits wide in the low half
// Notes:   printed offsets are register indices; byte address is index * 4
package irs_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// bus widths and answers
	localparam int IRS_AW = 32;
	localparam int IRS_DW = 32;
	localparam int IRS_RW = 16;
	localparam int IRS_SW = 4;
	localparam int IRS_LANE_LO = 0;
	localparam logic [1:0] IRS_RESP_OKAY = 2'h0;
	localparam logic [1:0] IRS_RESP_DECERR = 2'h3;

	// ==========================================================
	// register indices and byte addresses
	localparam logic [IRS_AW-1:0] IRS_IDX_ROUTE = 32'h0F00_0098;
	localparam logic [IRS_AW-1:0] IRS_IDX_SOFT = 32'h0F00_009A;
	localparam logic [IRS_AW-1:0] IRS_IDX_STAT = 32'h0F00_00A0;
	localparam logic [IRS_AW-1:0] IRS_IDX_EVT_STAT = 32'h0F00_00C0;
	localparam logic [IRS_AW-1:0] IRS_IDX_EVT_MASK = 32'h0F00_00C2;
	localparam logic [IRS_AW-1:0] IRS_ADDR_ROUTE = {IRS_IDX_ROUTE[29:0], 2'h0};
	localparam logic [IRS_AW-1:0] IRS_ADDR_SOFT = {IRS_IDX_SOFT[29:0], 2'h0};
	localparam logic [IRS_AW-1:0] IRS_ADDR_STAT = {IRS_IDX_STAT[29:0], 2'h0};
	localparam logic [IRS_AW-1:0] IRS_ADDR_EVT_STAT = {IRS_IDX_EVT_STAT[29:0], 2'h0};
	localparam logic [IRS_AW-1:0] IRS_ADDR_EVT_MASK = {IRS_IDX_EVT_MASK[29:0], 2'h0};

	// ==========================================================
	// field layout
	localparam int IRS_ROUTE_BIT = 0;
	localparam int IRS_BIT_BUS_CONTROL = 9;
	localparam int IRS_BIT_CLOCKED_SERIAL = 8;
	localparam int IRS_BIT_SYSTEM_CONTROL = 7;
	localparam int IRS_BIT_PCI_BRIDGE = 6;
	localparam int IRS_BIT_DEBUG_SERIAL = 5;
	localparam int IRS_BIT_FAST_INFRARED = 4;
	localparam int IRS_BIT_TCLOCK_COUNTER = 3;
	localparam int IRS_BIT_RESERVED = 2;
	localparam int IRS_BIT_INDICATOR = 1;
	localparam int IRS_BIT_RTC_LONG_TWO = 0;
	localparam int IRS_FLAG_TOP = 9;
	localparam logic [IRS_RW-1:0] IRS_STAT_MASK = 16'h03FB;
	localparam logic [IRS_RW-1:0] IRS_REG_RESET = 16'h0000;
	localparam logic [IRS_SW-1:0] IRS_SOFT_RESET = 4'h0;

	// ==========================================================
	// event bank
	localparam int IRS_EVT_W = 3;
	localparam int IRS_EVT_LOWBAT = 0;
	localparam int IRS_EVT_FLAG = 1;
	localparam int IRS_EVT_SOFT = 2;
	localparam logic [IRS_EVT_W-1:0] IRS_EVT_CLEAR = 3'h0;
endpackage : irs_pkg

// >>> irs_evt_if.sv
// Purpose: carrier between the register block and its sticky event bank
// Assumes: single clock domain
// Notes:   set and clr are one-cycle pulses per bit
interface irs_evt_if import irs_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic [IRS_EVT_W-1:0] set;
	logic [IRS_EVT_W-1:0] clr;
	logic [IRS_EVT_W-1:0] mask;
	logic [IRS_EVT_W-1:0] status;
	logic pending;
	modport bank (input set, input clr, input mask, output status, output pending);
	modport ctl (output set, output clr, output mask, input status, input pending);
endinterface : irs_evt_if

// >>> irs_sticky_bank.sv
// Purpose: sticky event flags with write-one-to-clear and mask
// Assumes: clr comes from a bus write, set from block logic
// Notes:   a set in the clearing cycle survives the clear
module irs_sticky_bank import irs_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// event carrier
	irs_evt_if.bank evt
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// flag update
	logic [IRS_EVT_W-1:0] next_status;

	// set beats clear so no event is lost
	assign next_status = (evt.status & ~evt.clr) | evt.set;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			evt.status <= IRS_EVT_CLEAR;
		end else begin
			evt.status <= next_status;
		end
	end

	assign evt.pending = |(evt.status & evt.mask);
endmodule : irs_sticky_bank

// >>> irs_route_soft_status.sv
// Purpose: low-battery route selector, software request register and
//          status-two flags, with AXI4-Lite access and a unit interrupt
// Assumes: source requests and mask inputs synchronous to sys_clk
// Notes:   registers sit in the low 16 bits of each word
//
// Local design decision: register access over AXI4-Lite.
module irs_route_soft_status import irs_pkg::*; (
	// clock and resets
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rtc_domain_reset,
	// axi4-lite write address
	input wire logic [IRS_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [IRS_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [IRS_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [IRS_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// on-chip request sources
	input wire logic low_battery_req,
	input wire logic bus_control_req,
	input wire logic clocked_serial_req,
	input wire logic system_control_req,
	input wire logic pci_bridge_req,
	input wire logic debug_serial_req,
	input wire logic fast_infrared_req,
	input wire logic tclock_counter_req,
	input wire logic indicator_req,
	input wire logic rtc_long_two_req,
	// enable masks held elsewhere
	input wire logic software_irq_enable,
	input wire logic [IRS_RW-1:0] system_mask_two,
	// cpu core lines
	output logic cpu_nmi,
	output logic cpu_int0,
	output logic [IRS_SW-1:0] cpu_soft_req,
	// unit interrupt
	output logic irq
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// state
	logic low_battery_route_select;
	logic [IRS_SW-1:0] software_request_bits;
	logic [IRS_RW-1:0] flag_status;
	logic [IRS_EVT_W-1:0] evt_mask;
	logic lowbat_prev;
	logic aw_held;
	logic [IRS_AW-1:0] aw_addr_q;
	logic w_held;
	logic [IRS_DW-1:0] w_data_q;
	logic [3:0] w_strb_q;

	irs_evt_if evt ();

	irs_sticky_bank u_bank (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.evt(evt)
	);

	// ==========================================================
	// write channel decode
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire bus_done = s_axi_bvalid & s_axi_bready;
	// both halves held and no answer pending
	wire wr_go = aw_held & w_held & ~s_axi_bvalid;
	wire lane_lo = w_strb_q[IRS_LANE_LO];
	wire [IRS_RW-1:0] wr_word = w_data_q[IRS_RW-1:0];
	wire wr_route = wr_go & (aw_addr_q == IRS_ADDR_ROUTE);
	wire wr_soft = wr_go & (aw_addr_q == IRS_ADDR_SOFT);
	wire wr_stat = wr_go & (aw_addr_q == IRS_ADDR_STAT);
	wire wr_estat = wr_go & (aw_addr_q == IRS_ADDR_EVT_STAT);
	wire wr_emask = wr_go & (aw_addr_q == IRS_ADDR_EVT_MASK);
	wire wr_hit = wr_route | wr_soft | wr_stat | wr_estat | wr_emask;
	// reserved write bits dropped
	// every writable field lives in the low byte lane
	wire route_we = wr_route & lane_lo;
	wire soft_we = wr_soft & lane_lo;
	wire estat_we = wr_estat & lane_lo;
	wire emask_we = wr_emask & lane_lo;

	assign s_axi_awready = ~aw_held;
	assign s_axi_wready = ~w_held;

	wire next_aw_held = aw_take | (aw_held & ~wr_go);
	wire next_w_held = w_take | (w_held & ~wr_go);
	wire next_bvalid = wr_go | (s_axi_bvalid & ~bus_done);
	wire [1:0] next_bresp = wr_hit ? IRS_RESP_OKAY : IRS_RESP_DECERR;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_bvalid <= next_bvalid;
		end
	end

	// address and data held apart, since either may arrive first
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			aw_addr_q <= '0;
		end else if (aw_take) begin
			aw_addr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (w_take) begin
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bresp <= IRS_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bresp <= next_bresp;
		end
	end

	// ==========================================================
	// route and software request registers
	logic next_route;
	logic [IRS_SW-1:0] next_soft;

	always_comb begin
		next_route = low_battery_route_select;
		next_soft = software_request_bits;
		if (rtc_domain_reset) begin
			next_route = IRS_REG_RESET[IRS_ROUTE_BIT];
			next_soft = IRS_SOFT_RESET;
		end else begin
			if (route_we) begin
				next_route = wr_word[IRS_ROUTE_BIT];
			end
			if (soft_we) begin
				next_soft = wr_word[IRS_SW-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			low_battery_route_select <= IRS_REG_RESET[IRS_ROUTE_BIT];
		end else begin
			low_battery_route_select <= next_route;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			software_request_bits <= IRS_SOFT_RESET;
		end else begin
			software_request_bits <= next_soft;
		end
	end

	// ==========================================================
	// status-two flags
	wire [IRS_RW-1:0] flag_src;
	assign flag_src[IRS_BIT_BUS_CONTROL] = bus_control_req;
	assign flag_src[IRS_BIT_CLOCKED_SERIAL] = clocked_serial_req;
	assign flag_src[IRS_BIT_SYSTEM_CONTROL] = system_control_req;
	assign flag_src[IRS_BIT_PCI_BRIDGE] = pci_bridge_req;
	assign flag_src[IRS_BIT_DEBUG_SERIAL] = debug_serial_req;
	assign flag_src[IRS_BIT_FAST_INFRARED] = fast_infrared_req;
	assign flag_src[IRS_BIT_TCLOCK_COUNTER] = tclock_counter_req;
	assign flag_src[IRS_BIT_RESERVED] = 1'b0;
	assign flag_src[IRS_BIT_INDICATOR] = indicator_req;
	assign flag_src[IRS_BIT_RTC_LONG_TWO] = rtc_long_two_req;
	assign flag_src[IRS_RW-1:IRS_FLAG_TOP+1] = '0;

	wire [IRS_RW-1:0] next_flags = rtc_domain_reset ? IRS_REG_RESET :
		(flag_src & IRS_STAT_MASK);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flag_status <= IRS_REG_RESET;
		end else begin
			flag_status <= next_flags;
		end
	end

	// ==========================================================
	// events into the sticky bank
	// rises only, so a held source raises one event
	wire lowbat_rise = low_battery_req & ~lowbat_prev;
	wire flag_rise = |(next_flags & ~flag_status);
	wire soft_rise = |(next_soft & ~software_request_bits);
	wire [IRS_EVT_W-1:0] next_emask = emask_we ? wr_word[IRS_EVT_W-1:0] : evt_mask;

	assign evt.set[IRS_EVT_LOWBAT] = lowbat_rise;
	assign evt.set[IRS_EVT_FLAG] = flag_rise;
	assign evt.set[IRS_EVT_SOFT] = soft_rise;
	assign evt.clr = estat_we ? wr_word[IRS_EVT_W-1:0] : IRS_EVT_CLEAR;
	assign evt.mask = evt_mask;
	assign irq = evt.pending;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lowbat_prev <= 1'b0;
			evt_mask <= IRS_EVT_CLEAR;
		end else begin
			lowbat_prev <= low_battery_req;
			evt_mask <= next_emask;
		end
	end

	// ==========================================================
	// cpu core lines
	// selector picks int0 or nmi
	wire lowbat_to_int0 = low_battery_req & low_battery_route_select;
	wire lowbat_to_nmi = low_battery_req & ~low_battery_route_select;
	wire [IRS_SW-1:0] soft_fwd = software_request_bits & {IRS_SW{software_irq_enable}};
	wire [IRS_RW-1:0] flag_fwd = flag_status & system_mask_two & IRS_STAT_MASK;
	wire next_int0 = lowbat_to_int0 | (|soft_fwd) | (|flag_fwd);

	// lines leave flops so the core never sees a decode glitch
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cpu_nmi <= 1'b0;
		end else begin
			cpu_nmi <= lowbat_to_nmi;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cpu_int0 <= 1'b0;
		end else begin
			cpu_int0 <= next_int0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cpu_soft_req <= IRS_SOFT_RESET;
		end else begin
			cpu_soft_req <= soft_fwd;
		end
	end

	// ==========================================================
	// read channel
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire rd_route = (s_axi_araddr == IRS_ADDR_ROUTE);
	wire rd_soft = (s_axi_araddr == IRS_ADDR_SOFT);
	wire rd_stat = (s_axi_araddr == IRS_ADDR_STAT);
	wire rd_estat = (s_axi_araddr == IRS_ADDR_EVT_STAT);
	wire rd_emask = (s_axi_araddr == IRS_ADDR_EVT_MASK);
	wire rd_hit = rd_route | rd_soft | rd_stat | rd_estat | rd_emask;
	wire [IRS_RW-1:0] route_word = {{(IRS_RW-1){1'b0}}, low_battery_route_select};
	wire [IRS_RW-1:0] soft_word = {{(IRS_RW-IRS_SW){1'b0}}, software_request_bits};
	wire [IRS_RW-1:0] estat_word = {{(IRS_RW-IRS_EVT_W){1'b0}}, evt.status};
	wire [IRS_RW-1:0] emask_word = {{(IRS_RW-IRS_EVT_W){1'b0}}, evt_mask};
	// unmapped reads return zero with decode error
	// and-or select: a missed decode reads zero, never a stale word
	wire [IRS_RW-1:0] rd_route_part = route_word & {IRS_RW{rd_route}};
	wire [IRS_RW-1:0] rd_soft_part = soft_word & {IRS_RW{rd_soft}};
	wire [IRS_RW-1:0] rd_stat_part = flag_status & {IRS_RW{rd_stat}};
	wire [IRS_RW-1:0] rd_estat_part = estat_word & {IRS_RW{rd_estat}};
	wire [IRS_RW-1:0] rd_emask_part = emask_word & {IRS_RW{rd_emask}};
	wire [IRS_RW-1:0] rd_word = rd_route_part | rd_soft_part | rd_stat_part |
		rd_estat_part | rd_emask_part;
	wire [IRS_DW-1:0] next_rdata = {{(IRS_DW-IRS_RW){1'b0}}, rd_word};
	wire [1:0] next_rresp = rd_hit ? IRS_RESP_OKAY : IRS_RESP_DECERR;
	wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

	// one read in flight keeps rdata stable until taken
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_rvalid <= next_rvalid;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rdata <= '0;
			s_axi_rresp <= IRS_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule : irs_route_soft_status

// >>> irs_route_soft_status_props.sv
// Purpose: port checker for irs_route_soft_status
// Assumes: one clock, rstn async low
// Notes:   read address kept to judge the reserved bits
module irs_route_soft_status_props import irs_pkg::*; (
	// clock and resets
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rtc_domain_reset,
	// read channel
	input wire logic [IRS_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [IRS_DW-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// sources and masks
	input wire logic low_battery_req,
	input wire logic bus_control_req,
	input wire logic software_irq_enable,
	input wire logic [IRS_RW-1:0] system_mask_two,
	// cpu lines
	input wire logic cpu_nmi,
	input wire logic cpu_int0,
	input wire logic [IRS_SW-1:0] cpu_soft_req
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// read address capture
	logic [IRS_AW-1:0] rd_addr;
	logic [15:0] rd_lo;
	assign rd_lo = s_axi_rdata[15:0];
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_addr <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_addr <= s_axi_araddr;
		end
	end
	// ==========================================
	// properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence flag_raised;
		bus_control_req && !rtc_domain_reset;
	endsequence
	sequence flag_enabled;
		system_mask_two[IRS_BIT_BUS_CONTROL] && !rtc_domain_reset;
	endsequence
	a_nmi_from_lowbat:
	assert property (cpu_nmi |-> $past(low_battery_req)) else $error("nmi without cause");
	a_soft_needs_enable:
	assert property (cpu_soft_req != '0 |-> $past(software_irq_enable))
		else $error("soft request while disabled");
	a_int0_has_cause:
	assert property (cpu_int0 |-> $past(low_battery_req) || $past(software_irq_enable)
		|| ($past(system_mask_two) & IRS_STAT_MASK) != '0) else $error("int0 without cause");
	a_flag_reaches_int0:
	assert property (flag_raised ##1 flag_enabled |=> cpu_int0) else $error("flag lost");
	a_rtc_clears_soft:
	assert property (rtc_domain_reset [*2] |=> cpu_soft_req == '0) else $error("soft kept");
	a_read_upper_zero:
	assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == '0) else $error("upper bits set");
	a_status_resv_zero:
	assert property (s_axi_rvalid && rd_addr == IRS_ADDR_STAT |-> (rd_lo & ~IRS_STAT_MASK) == '0)
		else $error("status reserved set");
	a_route_resv_zero:
	assert property (s_axi_rvalid && rd_addr == IRS_ADDR_ROUTE |-> rd_lo[15:1] == '0)
		else $error("route reserved set");
endmodule : irs_route_soft_status_props

bind irs_route_soft_status irs_route_soft_status_props u_props (.sys_clk, .rstn,
	.rtc_domain_reset, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .low_battery_req, .bus_control_req, .software_irq_enable,
	.system_mask_two, .cpu_nmi, .cpu_int0, .cpu_soft_req);

// >>> irs_cpu_model.sv
// Purpose: cpu core stand-in on the nmi line
// Assumes: nmi is a level synchronous to sys_clk
// Notes:   counts rising edges, since a core takes nmi on its edge
module irs_cpu_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// cpu line
	input wire logic nmi,
	// edges seen
	output int nmi_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic nmi_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			nmi_q <= 1'h0;
			nmi_count <= 0;
		end else begin
			nmi_q <= nmi;
			nmi_count <= nmi_count + int'(nmi && !nmi_q);
		end
	end
endmodule : irs_cpu_model

// >>> irs_route_soft_status_bench.sv
// Purpose: self-checking bench for irs_route_soft_status
// Assumes: 25 MHz sys_clk; outputs sampled at the falling edge
// Notes:   reserved bits written as zero, as software must; they still read zero
`define CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); \
	end \
end
module irs_route_soft_status_bench import irs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [IRS_AW-1:0] a; logic [15:0] d, e; logic [1:0] br, rr;} irs_row_t;
	// ==========================================
	// stimulus and observed signals
	logic sys_clk = 1'h0, rstn = 1'h0, rtc_domain_reset = 1'h0, low_battery_req = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, software_irq_enable = 1'h0;
	logic [IRS_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [IRS_DW-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [IRS_RW-1:0] system_mask_two = '0;
	logic [9:0] src = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic cpu_nmi, cpu_int0, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
	logic [IRS_SW-1:0] cpu_soft_req;
	int nmi_count, err_count = 0, tests_run = 0;
	irs_row_t rows [6];
	localparam logic [IRS_AW-1:0] REGS [3] = '{IRS_ADDR_ROUTE, IRS_ADDR_SOFT, IRS_ADDR_STAT};

	irs_route_soft_status dut (.*, .bus_control_req(src[9]), .clocked_serial_req(src[8]),
		.system_control_req(src[7]), .pci_bridge_req(src[6]), .debug_serial_req(src[5]),
		.fast_infrared_req(src[4]), .tclock_counter_req(src[3]), .indicator_req(src[1]),
		.rtc_long_two_req(src[0]));
	irs_cpu_model cpu (.sys_clk, .rstn, .nmi(cpu_nmi), .nmi_count);

	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	// ==========================================
	// tasks
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : step
	// each channel released only after the edge that takes it
	task automatic bus_write(input logic [IRS_AW-1:0] a, input logic [IRS_DW-1:0] d,
		output logic [1:0] r);
		logic aw_ok, w_ok, b_ok;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		b_ok = 1'h0;
		for (int n = 0; n < 50 && !b_ok; n++) begin
			@(negedge sys_clk);
			aw_ok = s_axi_awvalid && s_axi_awready;
			w_ok = s_axi_wvalid && s_axi_wready;
			b_ok = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge sys_clk);
			if (aw_ok) s_axi_awvalid <= 1'h0;
			if (w_ok) s_axi_wvalid <= 1'h0;
			if (b_ok) s_axi_bready <= 1'h0;
		end
		if (!b_ok) begin
			err_count++;
			summarize();
		end
	endtask : bus_write
	task automatic bus_read(input logic [IRS_AW-1:0] a, output logic [IRS_DW-1:0] d,
		output logic [1:0] r);
		logic ar_ok, r_ok;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		r_ok = 1'h0;
		for (int n = 0; n < 50 && !r_ok; n++) begin
			@(negedge sys_clk);
			ar_ok = s_axi_arvalid && s_axi_arready;
			r_ok = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge sys_clk);
			if (ar_ok) s_axi_arvalid <= 1'h0;
			if (r_ok) s_axi_rready <= 1'h0;
		end
		if (!r_ok) begin
			err_count++;
			summarize();
		end
	endtask : bus_read
	task automatic check_clear();
		for (int i = 0; i < 3; i++) begin
			bus_read(REGS[i], rd, rr);
			`CHK(rd, 32'h0)
		end
	endtask : check_clear
	// ==========================================
	// main sequence
	initial begin
		rows = '{'{IRS_ADDR_ROUTE, 16'h0001, 16'h0001, IRS_RESP_OKAY, IRS_RESP_OKAY},
			'{IRS_ADDR_SOFT, 16'h000F, 16'h000F, IRS_RESP_OKAY, IRS_RESP_OKAY},
			'{IRS_ADDR_SOFT, 16'h0005, 16'h0005, IRS_RESP_OKAY, IRS_RESP_OKAY},
			'{IRS_ADDR_SOFT, 16'h0002, 16'h0002, IRS_RESP_OKAY, IRS_RESP_OKAY},
			'{IRS_ADDR_STAT, 16'h03FB, 16'h0000, IRS_RESP_OKAY, IRS_RESP_OKAY},
			'{32'h0000_0010, 16'hFFFF, 16'h0000, IRS_RESP_DECERR, IRS_RESP_DECERR}};
		repeat (20) @(posedge sys_clk);
		rstn <= 1'h1;
		check_clear();
		foreach (rows[i]) begin
			bus_write(rows[i].a, {16'h0, rows[i].d}, br);
			bus_read(rows[i].a, rd, rr);
			`CHK({br, rr, rd}, {rows[i].br, rows[i].rr, 16'h0, rows[i].e})
		end
		$display("register rows done");
		for (int i = 0; i < 11; i++) begin
			@(posedge sys_clk);
			src <= (i == 10) ? 10'h3FF : 10'h1 << i;
			step(2);
			bus_read(IRS_ADDR_STAT, rd, rr);
			`CHK(rd, ((i == 10) ? 32'h3FF : 32'h1 << i) & IRS_STAT_MASK)
		end
		`CHK(cpu_int0, 1'h0)
		@(posedge sys_clk);
		system_mask_two <= IRS_STAT_MASK;
		step(2);
		`CHK(cpu_int0, 1'h1)
		$display("status flags done");
		@(posedge sys_clk);
		src <= '0;
		system_mask_two <= '0;
		step(2);
		`CHK(cpu_soft_req, 4'h0)
		@(posedge sys_clk);
		software_irq_enable <= 1'h1;
		step(2);
		`CHK({cpu_soft_req, cpu_int0}, 5'h5)
		$display("soft gating done");
		@(posedge sys_clk);
		software_irq_enable <= 1'h0;
		low_battery_req <= 1'h1;
		step(2);
		`CHK({cpu_int0, cpu_nmi, nmi_count}, {2'h2, 32'h0})
		@(posedge sys_clk);
		low_battery_req <= 1'h0;
		bus_write(IRS_ADDR_ROUTE, 32'h0, br);
		@(posedge sys_clk);
		low_battery_req <= 1'h1;
		step(2);
		`CHK({cpu_int0, cpu_nmi, nmi_count}, {2'h1, 32'h1})
		$display("route done");
		bus_write(IRS_ADDR_EVT_MASK, 32'h1, br);
		step(0);
		`CHK(irq, 1'h1)
		bus_write(IRS_ADDR_EVT_STAT, 32'h7, br);
		bus_read(IRS_ADDR_EVT_STAT, rd, rr);
		step(0);
		`CHK({irq, rd}, 33'h0)
		@(posedge sys_clk);
		low_battery_req <= 1'h0;
		@(posedge sys_clk);
		low_battery_req <= 1'h1;
		step(2);
		`CHK(irq, 1'h1)
		bus_write(IRS_ADDR_EVT_MASK, 32'h0, br);
		bus_read(IRS_ADDR_EVT_STAT, rd, rr);
		step(0);
		`CHK({irq, rd}, 33'h1)
		$display("interrupt done");
		@(posedge sys_clk);
		low_battery_req <= 1'h0;
		s_axi_wstrb <= 4'hE;
		bus_write(IRS_ADDR_ROUTE, 32'h1, br);
		bus_read(IRS_ADDR_ROUTE, rd, rr);
		`CHK({br, rd}, {IRS_RESP_OKAY, 32'h0})
		@(posedge sys_clk);
		s_axi_wstrb <= 4'hF;
		bus_write(IRS_ADDR_ROUTE, 32'h1, br);
		bus_write(IRS_ADDR_SOFT, 32'hF, br);
		// live sources during the clear prove the flags are held at zero
		@(posedge sys_clk);
		rtc_domain_reset <= 1'h1;
		src <= 10'h3FF;
		repeat (2) @(posedge sys_clk);
		check_clear();
		@(posedge sys_clk);
		rtc_domain_reset <= 1'h0;
		src <= '0;
		bus_write(IRS_ADDR_ROUTE, 32'h1, br);
		@(posedge sys_clk);
		rstn <= 1'h0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'h1;
		check_clear();
		$display("resets done");
		summarize();
	end
endmodule : irs_route_soft_status_bench
